// [logic/source_cmd_pkg.sv]
// constants, command and answer carriers for the source setpoint command engine
// Operation
// - a setpoint command with no parameter answers the held setpoint and changes nothing.
// - the default keyword copies the setpoint in force into nonvolatile storage.
// - after power-up every setpoint is loaded from its stored default before commands.
// - indexed voltage commands for phases 1 to 3 touch only that phase, unindexed the common.
// - a dc offset setpoint exists overall and per phase, handled like the ac voltage.
// - user wave load selects one of three slots or the output; a slot load takes about 170 ms.
// - the waveform select command switches the generator to the numbered wave shape.
// - the sync input command enables the sync input on set and disables it on reset.
// - clear status clears the status byte of the arriving interface and sends no answer.
// - cyclic mode alternates the output on for the on time and off for the off time.
// - cyclic mode ends on its reset argument and whenever standby deactivates the output.
// - device clear restores all initialization data to factory values with no answer.
// - the dip command takes up to 30000 ms and reports the stored time without a parameter.
// - dip start waits for the reference zero crossing, then drops the output for the time.
// - frequency commands set the frequency; the default keyword stores it permanently.
// - a setpoint above the maximum sets the range error bit and keeps the old setpoint.
package source_cmd_pkg;

  typedef enum logic [3:0] {
    OP_VOLT_SET = 4'h0,
    OP_AC_VOLT_DEFAULT = 4'h1,
    OP_DC_OFFSET = 4'h2,
    OP_FREQ_SET = 4'h3,
    OP_FREQ_DEFAULT = 4'h4,
    OP_USER_WAVE_LOAD = 4'h5,
    OP_WAVE_SELECT = 4'h6,
    OP_SYNC_INPUT = 4'h7,
    OP_CLEAR_STATUS = 4'h8,
    OP_CYCLE = 4'h9,
    OP_STANDBY = 4'hA,
    OP_DEVICE_CLEAR = 4'hB,
    OP_OUTPUT_DIP = 4'hC
  } cmd_op_type;

  typedef enum logic [2:0] {
    ARG_NONE = 3'h0,
    ARG_VALUE = 3'h1,
    ARG_DEFAULT = 3'h2,
    ARG_SET = 3'h3,
    ARG_RESET = 3'h4,
    ARG_PAIR = 3'h5
  } cmd_arg_type;

  typedef struct packed {
    cmd_op_type op;
    logic [1:0] phase;
    logic [1:0] iface;
    cmd_arg_type arg;
    logic [15:0] value;
    logic [15:0] value2;
  } cmd_type;

  typedef struct packed {
    cmd_op_type op;
    logic [1:0] phase;
    logic [1:0] iface;
    logic [15:0] value;
  } rsp_type;

  typedef struct packed {
    logic [3:0] key;
    logic [15:0] value;
  } nv_word_type;

  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_SEC = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_SEC;
  localparam int CYCLES_PER_SEC = CLK_HZ;
  localparam logic [15:0] WAVE_LOAD_MS = 16'h00AA;
  localparam logic [15:0] DIP_MAX_MS = 16'h7530;

  localparam int SETPOINT_COUNT = 9;
  localparam logic [3:0] KEY_VOLT = 4'h0;
  localparam logic [3:0] KEY_DC = 4'h4;
  localparam logic [3:0] KEY_FREQ = 4'h8;
  localparam logic [3:0] LAST_KEY = 4'(SETPOINT_COUNT - 1);

  localparam logic [15:0] FACTORY_VOLT = 16'h0000;
  localparam logic [15:0] FACTORY_DC = 16'h0000;
  localparam logic [15:0] FACTORY_FREQ = 16'h01F4;
  localparam logic [15:0] FACTORY_DIP_MS = 16'h0000;
  localparam logic [15:0] FACTORY_CYCLE_S = 16'h0001;
  localparam logic [7:0] FACTORY_WAVE = 8'h00;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int STATUS_RANGE_BIT = 3;
  localparam logic [1:0] SLOT_OUTPUT = 2'h0;
  localparam logic [15:0] LAST_SLOT = 16'h0003;

endpackage

// [logic/unit_timer.sv]
// countdown of whole time units with a cycle prescaler
`timescale 1ns/1ps
module unit_timer #(
  parameter int UNIT_CYCLES = 20000,
  parameter int COUNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [COUNT_W-1:0] units,
  output logic busy,
  output logic done
);
  localparam int PRE_W = $clog2(UNIT_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);

  logic [PRE_W-1:0] pre;
  logic [COUNT_W-1:0] left;
  logic unit_end;

  if (UNIT_CYCLES < 1 || COUNT_W < 1) begin : g_bad_param
    $error("unit_timer needs a positive unit and width");
  end

  assign unit_end = busy && (pre == PRE_LAST);

  // a zero count still runs one unit: the load is never shorter than a tick
  always_ff @(posedge sys_clk) begin
    if (rst || stop) begin
      busy <= 1'b0;
      done <= 1'b0;
      pre <= '0;
      left <= '0;
    end else if (start) begin
      busy <= 1'b1;
      done <= 1'b0;
      pre <= '0;
      left <= units;
    end else begin
      done <= unit_end && (left <= COUNT_W'(1));
      if (unit_end) begin
        pre <= '0;
        busy <= left > COUNT_W'(1);
        left <= left - COUNT_W'(1);
      end else if (busy) begin
        pre <= pre + PRE_W'(1);
      end
    end
  end
endmodule // unit_timer

// [logic/source_setpoint_command_engine.sv]
// decoded remote command engine: setpoints, defaults, wave, cycle and dip control
`timescale 1ns/1ps
module source_setpoint_command_engine
  import source_cmd_pkg::*;
#(
  parameter logic [15:0] VOLT_MAX = 16'h1388,
  parameter logic [15:0] DC_MAX = 16'h1388,
  parameter logic [15:0] FREQ_MAX = 16'h1388,
  parameter logic [7:0] WAVE_MAX = 8'h0F,
  parameter int IFACE_COUNT = 4,
  parameter int MS_CYCLES = CYCLES_PER_MS,
  parameter int SEC_CYCLES = CYCLES_PER_SEC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_type cmd,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output rsp_type rsp,
  output logic nv_rd_req,
  output logic [3:0] nv_rd_key,
  input wire logic nv_rd_valid,
  input wire logic [15:0] nv_rd_data,
  output logic nv_wr_valid,
  input wire logic nv_wr_ready,
  output nv_word_type nv_wr,
  input wire logic zero_cross,
  output logic [SETPOINT_COUNT-1:0][15:0] setpoint,
  output logic [15:0] dip_ms,
  output logic [7:0] wave_number,
  output logic user_wave_on_output,
  output logic wave_slot_load,
  output logic [1:0] wave_slot,
  output logic wave_load_busy,
  output logic sync_in_enable,
  output logic output_active,
  output logic factory_restore,
  output logic init_done,
  output logic [IFACE_COUNT-1:0][7:0] status_byte
);
  typedef enum logic [2:0] {
    ST_LOAD_REQ = 3'b000,
    ST_LOAD_WAIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_RESPOND = 3'b011,
    ST_STORE = 3'b100,
    ST_CLEAR = 3'b101,
    ST_WAVE_LOAD = 3'b110
  } state_type;

  if (IFACE_COUNT < 1 || IFACE_COUNT > 4) begin : g_bad_iface
    $error("interface count must be 1 to 4");
  end
  if (MS_CYCLES < 1 || SEC_CYCLES < 1) begin : g_bad_time
    $error("time units must be at least one cycle");
  end

  function automatic logic [3:0] key_of(input cmd_op_type op, input logic [1:0] phase);
    logic [3:0] k;
    k = KEY_FREQ;
    if (op == OP_VOLT_SET || op == OP_AC_VOLT_DEFAULT) k = KEY_VOLT + {2'b00, phase};
    else if (op == OP_DC_OFFSET) k = KEY_DC + {2'b00, phase};
    return k;
  endfunction

  function automatic logic [15:0] max_of(input logic [3:0] key);
    return (key < KEY_DC) ? VOLT_MAX : (key < KEY_FREQ) ? DC_MAX : FREQ_MAX;
  endfunction

  function automatic logic [15:0] factory_of(input logic [3:0] key);
    return (key < KEY_DC) ? FACTORY_VOLT : (key < KEY_FREQ) ? FACTORY_DC : FACTORY_FREQ;
  endfunction

  state_type state;
  logic [3:0] load_key;
  logic [15:0] cycle_on_s;
  logic [15:0] cycle_off_s;
  logic cycle_run;
  logic cycle_in_on;
  logic dip_armed;
  logic dip_active;
  logic output_enabled;
  logic [7:0] iface_status [IFACE_COUNT];

  wire [3:0] next_key = load_key + 4'h1;
  wire take = cmd_valid && cmd_ready;
  wire [1:0] cmd_phase = cmd.phase;
  wire [1:0] cmd_iface = cmd.iface;
  wire [15:0] cmd_value = cmd.value;
  wire [3:0] cmd_key = key_of(cmd.op, cmd.phase);
  wire is_setpoint = cmd.op inside {OP_VOLT_SET, OP_AC_VOLT_DEFAULT, OP_DC_OFFSET,
                                    OP_FREQ_SET, OP_FREQ_DEFAULT};
  wire has_value = cmd.arg == ARG_VALUE;
  wire cmd_over = cmd_value > max_of(cmd_key);
  wire dip_over = cmd_value > DIP_MAX_MS;
  wire wave_over = (cmd_value[15:8] != 8'h00) || (cmd_value[7:0] > WAVE_MAX);
  wire slot_over = cmd_value > LAST_SLOT;
  wire is_query = take && cmd.arg == ARG_NONE && (is_setpoint || cmd.op == OP_OUTPUT_DIP
                  || cmd.op == OP_WAVE_SELECT || cmd.op == OP_SYNC_INPUT);
  wire is_store = take && is_setpoint && cmd.arg == ARG_DEFAULT;
  wire set_write = take && is_setpoint && has_value && !cmd_over;
  wire dev_clear = take && cmd.op == OP_DEVICE_CLEAR;
  wire clear_stat = take && cmd.op == OP_CLEAR_STATUS;
  wire reject = take && has_value && ((is_setpoint && cmd_over)
                || (cmd.op == OP_OUTPUT_DIP && dip_over)
                || (cmd.op == OP_WAVE_SELECT && wave_over)
                || (cmd.op == OP_USER_WAVE_LOAD && slot_over));
  wire wave_cmd = take && cmd.op == OP_USER_WAVE_LOAD && has_value && !slot_over;
  wire slot_load = wave_cmd && cmd_value[1:0] != SLOT_OUTPUT;
  wire sync_arg_set = cmd.arg == ARG_SET;
  wire cycle_start = take && cmd.op == OP_CYCLE && cmd.arg == ARG_SET;
  wire cycle_end = dev_clear || (take && ((cmd.op == OP_CYCLE && cmd.arg == ARG_RESET)
                   || (cmd.op == OP_STANDBY && cmd.arg == ARG_SET)));
  wire dip_fire = dip_armed && zero_cross;
  wire [15:0] query_value = is_setpoint ? setpoint[cmd_key]
                            : (cmd.op == OP_OUTPUT_DIP) ? dip_ms
                            : (cmd.op == OP_WAVE_SELECT) ? {8'h00, wave_number}
                            : {15'h0000, sync_in_enable};
  wire next_output_active = output_enabled && !(cycle_run && !cycle_in_on) && !dip_active;
  logic wave_done;
  logic cyc_done;
  logic dip_done;

  assign cmd_ready = state == ST_IDLE;
  assign rsp_valid = state == ST_RESPOND;
  assign nv_rd_req = state == ST_LOAD_REQ;
  assign nv_rd_key = load_key;
  assign nv_wr_valid = state == ST_STORE || state == ST_CLEAR;
  assign wave_load_busy = state == ST_WAVE_LOAD;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_LOAD_REQ;
      load_key <= 4'h0;
      init_done <= 1'b0;
      rsp <= '0;
      nv_wr <= '0;
    end else begin
      unique case (state)
        ST_LOAD_REQ: state <= ST_LOAD_WAIT;
        ST_LOAD_WAIT: if (nv_rd_valid) begin
          load_key <= next_key;
          state <= (load_key == LAST_KEY) ? ST_IDLE : ST_LOAD_REQ;
          init_done <= load_key == LAST_KEY;
        end
        ST_IDLE: if (take) begin
          if (is_query) begin
            rsp <= '{op: cmd.op, phase: cmd.phase, iface: cmd.iface, value: query_value};
            state <= ST_RESPOND;
          end else if (is_store) begin
            nv_wr <= '{key: cmd_key, value: query_value};
            state <= ST_STORE;
          end else if (dev_clear) begin
            load_key <= 4'h0;
            nv_wr <= '{key: 4'h0, value: factory_of(4'h0)};
            state <= ST_CLEAR;
          end else if (slot_load) begin
            state <= ST_WAVE_LOAD;
          end
        end
        ST_RESPOND: if (rsp_ready) state <= ST_IDLE;
        ST_STORE: if (nv_wr_ready) state <= ST_IDLE;
        ST_CLEAR: if (nv_wr_ready) begin
          load_key <= next_key;
          nv_wr <= '{key: next_key, value: factory_of(next_key)};
          if (load_key == LAST_KEY) state <= ST_IDLE;
        end
        ST_WAVE_LOAD: if (wave_done) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || dev_clear) begin
      for (int i = 0; i < SETPOINT_COUNT; i++) setpoint[i] <= factory_of(4'(i));
    end else if (state == ST_LOAD_WAIT && nv_rd_valid) begin
      setpoint[load_key] <= nv_rd_data;
    end else if (set_write) begin
      setpoint[cmd_key] <= cmd_value;
    end
  end

  // factory restore also tells the comm interfaces to reset their parameters
  always_ff @(posedge sys_clk) begin
    if (rst || dev_clear) begin
      dip_ms <= FACTORY_DIP_MS;
      wave_number <= FACTORY_WAVE;
      user_wave_on_output <= 1'b0;
      sync_in_enable <= 1'b0;
      output_enabled <= 1'b0;
      cycle_on_s <= FACTORY_CYCLE_S;
      cycle_off_s <= FACTORY_CYCLE_S;
      wave_slot <= SLOT_OUTPUT;
    end else if (take) begin
      if (cmd.op == OP_OUTPUT_DIP && has_value && !dip_over) dip_ms <= cmd_value;
      if (cmd.op == OP_WAVE_SELECT && has_value && !wave_over) begin
        wave_number <= cmd_value[7:0];
        user_wave_on_output <= 1'b0;
      end
      if (wave_cmd) begin
        wave_slot <= cmd_value[1:0];
        user_wave_on_output <= !slot_load;
      end
      if (cmd.op == OP_SYNC_INPUT && cmd.arg inside {ARG_SET, ARG_RESET})
        sync_in_enable <= sync_arg_set;
      if (cmd.op == OP_STANDBY && cmd.arg inside {ARG_SET, ARG_RESET})
        output_enabled <= cmd.arg == ARG_RESET;
      if (cmd.op == OP_CYCLE && cmd.arg == ARG_PAIR) begin
        cycle_on_s <= cmd_value;
        cycle_off_s <= cmd.value2;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cycle_run <= 1'b0;
      cycle_in_on <= 1'b0;
      dip_armed <= 1'b0;
      dip_active <= 1'b0;
      output_active <= 1'b0;
      wave_slot_load <= 1'b0;
      factory_restore <= 1'b0;
    end else begin
      output_active <= next_output_active;
      wave_slot_load <= slot_load;
      factory_restore <= dev_clear;
      if (cycle_end) begin
        cycle_run <= 1'b0;
        cycle_in_on <= 1'b0;
      end else if (cycle_start) begin
        cycle_run <= 1'b1;
        cycle_in_on <= 1'b1;
      end else if (cycle_run && cyc_done) begin
        cycle_in_on <= !cycle_in_on;
      end
      if (take && cmd.op == OP_OUTPUT_DIP && cmd.arg == ARG_SET && dip_ms != 16'h0000)
        dip_armed <= 1'b1;
      else if (dip_fire)
        dip_armed <= 1'b0;
      if (dip_fire)
        dip_active <= 1'b1;
      else if (dip_done)
        dip_active <= 1'b0;
    end
  end

  for (genvar g = 0; g < IFACE_COUNT; g++) begin : g_status
    wire hit = cmd_iface == 2'(g);
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        iface_status[g] <= STATUS_RESET;
      end else begin
        if (clear_stat && hit) iface_status[g] <= STATUS_RESET;
        if (reject && hit) iface_status[g][STATUS_RANGE_BIT] <= 1'b1;
      end
    end
    assign status_byte[g] = iface_status[g];
  end

  unit_timer #(.UNIT_CYCLES(MS_CYCLES), .COUNT_W(16)) wave_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(slot_load),
    .stop(1'b0),
    .units(WAVE_LOAD_MS),
    .busy(),
    .done(wave_done)
  );

  // restart on each phase end so on and off alternate
  unit_timer #(.UNIT_CYCLES(SEC_CYCLES), .COUNT_W(16)) cycle_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(cycle_start || (cycle_run && cyc_done)),
    .stop(cycle_end),
    .units((cycle_start || !cycle_in_on) ? cycle_on_s : cycle_off_s),
    .busy(),
    .done(cyc_done)
  );

  unit_timer #(.UNIT_CYCLES(MS_CYCLES), .COUNT_W(16)) dip_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(dip_fire),
    .stop(1'b0),
    .units(dip_ms),
    .busy(),
    .done(dip_done)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_cycle_go;
    cycle_start && !cycle_end && output_enabled && !dip_armed && !dip_active;
  endsequence
  sequence s_standby_off;
    take && cmd.op == OP_STANDBY && cmd.arg == ARG_SET;
  endsequence

  a_query_answers: assert property (
    is_query && is_setpoint |=> rsp_valid && $stable(setpoint)
      && rsp.value == setpoint[$past(cmd_key)])
    else $error("setpoint query answered wrong or changed state");
  a_default_store: assert property (
    is_store |=> nv_wr_valid && nv_wr.key == $past(cmd_key)
      && nv_wr.value == setpoint[nv_wr.key])
    else $error("default store word wrong");
  a_load_gate: assert property (
    !init_done |-> !cmd_ready)
    else $error("command accepted before defaults loaded");
  a_load_copy: assert property (
    state == ST_LOAD_WAIT && nv_rd_valid |=> setpoint[$past(load_key)] == $past(nv_rd_data))
    else $error("stored default not loaded");
  a_phase_write: assert property (
    set_write && cmd.op == OP_VOLT_SET |=> setpoint[$past(cmd_phase)] == $past(cmd_value))
    else $error("voltage write missed its phase");
  a_dc_write: assert property (
    set_write && cmd.op == OP_DC_OFFSET
      |=> setpoint[{2'b01, $past(cmd_phase)}] == $past(cmd_value))
    else $error("dc offset write missed its phase");
  a_wave_busy: assert property (
    slot_load |=> (wave_load_busy && !cmd_ready)[*8])
    else $error("slot load did not hold the engine busy");
  a_sync_follow: assert property (
    take && cmd.op == OP_SYNC_INPUT && cmd.arg inside {ARG_SET, ARG_RESET}
      |=> sync_in_enable == $past(sync_arg_set))
    else $error("sync enable did not follow command");
  a_clear_status: assert property (
    clear_stat |=> iface_status[$past(cmd_iface)] == STATUS_RESET && !rsp_valid)
    else $error("status not cleared or answer sent");
  a_cycle_on: assert property (
    s_cycle_go |=> cycle_run && cycle_in_on ##1 output_active)
    else $error("cycle start did not drive output on");
  a_standby_stop: assert property (
    s_standby_off |=> !cycle_run ##1 !output_active)
    else $error("standby did not end cycle mode");
  a_dip_limit: assert property (
    take && cmd.op == OP_OUTPUT_DIP && has_value && dip_over
      |=> $stable(dip_ms) && iface_status[$past(cmd_iface)][STATUS_RANGE_BIT])
    else $error("dip time over limit accepted");
  a_dip_start: assert property (
    dip_fire |=> dip_active && !dip_armed ##1 !output_active)
    else $error("dip did not start at zero crossing");
  a_range_keep: assert property (
    take && is_setpoint && has_value && cmd_over
      |=> $stable(setpoint) && iface_status[$past(cmd_iface)][STATUS_RANGE_BIT])
    else $error("over range setpoint not refused");
endmodule // source_setpoint_command_engine

// [bench/nv_store_model.sv]
// nonvolatile default store that answers the engine's read and write requests
`timescale 1ns/1ps
module nv_store_model
  import source_cmd_pkg::*;
#(
  parameter int DELAY = 3
) (
  input wire logic sys_clk,
  input wire logic nv_rd_req,
  input wire logic [3:0] nv_rd_key,
  output logic nv_rd_valid,
  output logic [15:0] nv_rd_data,
  input wire logic nv_wr_valid,
  output logic nv_wr_ready,
  input wire nv_word_type nv_wr
);
  logic [15:0] mem [SETPOINT_COUNT];
  logic [3:0] key_held = 4'h0;
  int rd_wait = -1;
  int wr_wait = 0;
  initial begin
    for (int k = 0; k < SETPOINT_COUNT; k++) begin
      mem[k] = 16'h0100 + 16'(k);
    end
    nv_rd_valid = 1'b0;
    nv_rd_data = 16'hA5A5;
    nv_wr_ready = 1'b0;
  end
  always @(posedge sys_clk) begin
    nv_rd_valid <= 1'b0;
    // data line toggles when not valid, so a stale word never looks good
    nv_rd_data <= ~nv_rd_data;
    if (nv_rd_req) begin
      rd_wait <= nv_rd_key[0] ? DELAY : 0;
      key_held <= nv_rd_key;
    end else if (rd_wait == 0) begin
      nv_rd_valid <= 1'b1;
      nv_rd_data <= mem[key_held];
      rd_wait <= -1;
    end else if (rd_wait > 0) begin
      rd_wait <= rd_wait - 1;
    end
  end
  always @(posedge sys_clk) begin
    nv_wr_ready <= 1'b0;
    if (nv_wr_valid && !nv_wr_ready) begin
      if (wr_wait >= (nv_wr.key[0] ? DELAY : 0)) begin
        nv_wr_ready <= 1'b1;
        mem[nv_wr.key] <= nv_wr.value;
        wr_wait <= 0;
      end else begin
        wr_wait <= wr_wait + 1;
      end
    end
  end
endmodule // nv_store_model

// [bench/tb_top.sv]
// self-checking bench for the source setpoint command engine
`timescale 1ns/1ps
module tb_top;
  import source_cmd_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, rsp_ready = 1'b0, zero_cross = 1'b0;
  logic cmd_ready, rsp_valid, nv_rd_req, nv_rd_valid, nv_wr_valid, nv_wr_ready, init_done;
  logic wave_slot_load, wave_load_busy, sync_in_enable, output_active, factory_restore;
  logic user_wave_on_output;
  logic [3:0] nv_rd_key;
  logic [15:0] nv_rd_data, dip_ms;
  logic [7:0] wave_number;
  logic [1:0] wave_slot;
  logic [SETPOINT_COUNT-1:0][15:0] setpoint;
  logic [3:0][7:0] status_byte;
  cmd_type cmd = '0;
  rsp_type rsp;
  nv_word_type nv_wr;
  int fail_count = 0, check_count = 0, cycles = 0;

  // short time units keep the slot load and cycle runs brief
  source_setpoint_command_engine #(.MS_CYCLES(4), .SEC_CYCLES(10)) dut (.sys_clk, .rst,
    .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp_ready, .rsp, .nv_rd_req, .nv_rd_key,
    .nv_rd_valid, .nv_rd_data, .nv_wr_valid, .nv_wr_ready, .nv_wr, .zero_cross, .setpoint,
    .dip_ms, .wave_number, .user_wave_on_output, .wave_slot_load, .wave_slot, .wave_load_busy,
    .sync_in_enable, .output_active, .factory_restore, .init_done, .status_byte);
  nv_store_model nv (.sys_clk, .nv_rd_req, .nv_rd_key, .nv_rd_valid, .nv_rd_data,
    .nv_wr_valid, .nv_wr_ready, .nv_wr);

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      give_verdict();
    end
  end

  // wide enough for the three-setpoint concatenations of the clear test
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one framed command at a time
  task automatic send(input cmd_op_type op, input logic [1:0] ph, input cmd_arg_type arg,
      input logic [15:0] v = 16'h0000, input logic [15:0] v2 = 16'h0000,
      input logic [1:0] ifc = 2'h0);
    @(negedge sys_clk);
    cmd = '{op, ph, ifc, arg, v, v2};
    cmd_valid = 1'b1;
    for (int n = 0; n < 2000 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask

  task automatic query(input cmd_op_type op, input logic [1:0] ph, output logic [15:0] v);
    send(op, ph, ARG_NONE);
    v = (rsp_valid === 1'b1) ? rsp.value : 16'hDEAD;
    check(rsp.op, op);
    rsp_ready = 1'b1;
    @(negedge sys_clk);
    rsp_ready = 1'b0;
  endtask

  task automatic idle;
    for (int n = 0; n < 2000 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
  endtask

  task automatic run(input logic lvl, output int n);
    for (n = 0; n < 500 && output_active === lvl; n++) @(negedge sys_clk);
  endtask

  task automatic t_setpoints;
    logic [15:0] v;
    for (int k = 0; k < SETPOINT_COUNT; k++) check(setpoint[k], 16'h0100 + k);
    send(OP_VOLT_SET, 2'h2, ARG_VALUE, 16'h0777);
    check(setpoint[2], 16'h0777);
    check(setpoint[1], 16'h0101);
    send(OP_VOLT_SET, 2'h0, ARG_VALUE, 16'h0050);
    check(setpoint[0], 16'h0050);
    check(setpoint[3], 16'h0103);
    send(OP_DC_OFFSET, 2'h1, ARG_VALUE, 16'h0123);
    check(setpoint[5], 16'h0123);
    check(setpoint[4], 16'h0104);
    send(OP_FREQ_SET, 2'h0, ARG_VALUE, 16'h003C);
    check(setpoint[8], 16'h003C);
    query(OP_VOLT_SET, 2'h2, v);
    check(v, 16'h0777);
    check(setpoint[2], 16'h0777);
    query(OP_DC_OFFSET, 2'h1, v);
    check(v, 16'h0123);
    query(OP_FREQ_SET, 2'h0, v);
    check(v, 16'h003C);
    $display("test setpoints done");
  endtask

  task automatic t_range_status;
    send(OP_VOLT_SET, 2'h3, ARG_VALUE, 16'h1389, 16'h0000, 2'h1);
    check(setpoint[3], 16'h0103);
    check(status_byte[1][STATUS_RANGE_BIT], 1'b1);
    send(OP_OUTPUT_DIP, 2'h0, ARG_VALUE, DIP_MAX_MS + 16'h0001);
    check(dip_ms, FACTORY_DIP_MS);
    check(status_byte[0][STATUS_RANGE_BIT], 1'b1);
    send(OP_CLEAR_STATUS, 2'h0, ARG_NONE, 16'h0000, 16'h0000, 2'h1);
    check(rsp_valid, 1'b0);
    check(status_byte[1], STATUS_RESET);
    check(status_byte[0][STATUS_RANGE_BIT], 1'b1);
    $display("test range and status done");
  endtask

  task automatic t_defaults;
    send(OP_DC_OFFSET, 2'h3, ARG_VALUE, 16'h0234);
    send(OP_DC_OFFSET, 2'h3, ARG_DEFAULT);
    idle();
    check(nv.mem[7], 16'h0234);
    send(OP_AC_VOLT_DEFAULT, 2'h2, ARG_DEFAULT);
    idle();
    check(nv.mem[2], 16'h0777);
    send(OP_FREQ_DEFAULT, 2'h0, ARG_DEFAULT);
    idle();
    check(nv.mem[8], 16'h003C);
    $display("test defaults done");
  endtask

  task automatic t_wave_sync;
    int n;
    logic [15:0] v;
    send(OP_WAVE_SELECT, 2'h0, ARG_VALUE, 16'h0005);
    check(wave_number, 8'h05);
    send(OP_WAVE_SELECT, 2'h0, ARG_VALUE, 16'h0010);
    check(wave_number, 8'h05);
    query(OP_WAVE_SELECT, 2'h0, v);
    check(v, 16'h0005);
    send(OP_USER_WAVE_LOAD, 2'h0, ARG_VALUE, 16'h0000);
    check(user_wave_on_output, 1'b1);
    send(OP_USER_WAVE_LOAD, 2'h0, ARG_VALUE, 16'h0002);
    check({wave_slot_load, wave_slot}, 3'h6);
    for (n = 0; n < 2000 && wave_load_busy === 1'b1; n++) @(negedge sys_clk);
    // slot load spans 170 units of 4 cycles
    check(n >= 678 && n <= 682, 1'b1);
    send(OP_SYNC_INPUT, 2'h0, ARG_SET);
    check(sync_in_enable, 1'b1);
    send(OP_SYNC_INPUT, 2'h0, ARG_RESET);
    check(sync_in_enable, 1'b0);
    $display("test wave and sync done");
  endtask

  task automatic t_cycle;
    int n;
    send(OP_CYCLE, 2'h0, ARG_PAIR, 16'h0002, 16'h0003);
    send(OP_STANDBY, 2'h0, ARG_RESET);
    send(OP_CYCLE, 2'h0, ARG_SET);
    run(1'b1, n);
    run(1'b0, n);
    check(n >= 28 && n <= 32, 1'b1);
    run(1'b1, n);
    check(n >= 18 && n <= 22, 1'b1);
    repeat (5) @(negedge sys_clk);
    send(OP_STANDBY, 2'h0, ARG_SET);
    repeat (60) @(negedge sys_clk);
    check(output_active, 1'b0);
    send(OP_STANDBY, 2'h0, ARG_RESET);
    @(negedge sys_clk);
    // a cycle still running would drop the output within about 20 cycles
    run(1'b1, n);
    check(n, 500);
    send(OP_CYCLE, 2'h0, ARG_SET);
    repeat (5) @(negedge sys_clk);
    send(OP_CYCLE, 2'h0, ARG_RESET);
    run(1'b1, n);
    check(n, 500);
    $display("test cycle done");
  endtask

  task automatic t_dip;
    int n;
    logic [15:0] v;
    send(OP_STANDBY, 2'h0, ARG_RESET);
    send(OP_OUTPUT_DIP, 2'h0, ARG_VALUE, DIP_MAX_MS);
    check(dip_ms, DIP_MAX_MS);
    send(OP_OUTPUT_DIP, 2'h0, ARG_VALUE, 16'h0005);
    query(OP_OUTPUT_DIP, 2'h0, v);
    check(v, 16'h0005);
    send(OP_OUTPUT_DIP, 2'h0, ARG_SET);
    repeat (10) @(negedge sys_clk);
    check(output_active, 1'b1);
    zero_cross = 1'b1;
    @(negedge sys_clk);
    zero_cross = 1'b0;
    run(1'b1, n);
    check(n <= 2, 1'b1);
    run(1'b0, n);
    check(n >= 19 && n <= 21, 1'b1);
    $display("test dip done");
  endtask

  task automatic t_clear;
    send(OP_DEVICE_CLEAR, 2'h0, ARG_NONE);
    check(factory_restore, 1'b1);
    check({setpoint[2], setpoint[5], setpoint[8]}, {FACTORY_VOLT, FACTORY_DC, FACTORY_FREQ});
    idle();
    check(rsp_valid, 1'b0);
    check({nv.mem[0], nv.mem[7], nv.mem[8]}, {FACTORY_VOLT, FACTORY_DC, FACTORY_FREQ});
    $display("test device clear done");
  endtask

  initial begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    // no command taken while defaults are still loading
    check(cmd_ready, 1'b0);
    idle();
    check(init_done, 1'b1);
    t_setpoints();
    t_range_status();
    t_defaults();
    t_wave_sync();
    t_cycle();
    t_dip();
    t_clear();
    give_verdict();
  end
endmodule // tb_top
